// ===== design/dbg_trig_defines.svh
// register indices, field positions and reset values of the debug trigger unit
`ifndef DBG_TRIG_DEFINES_SVH
`define DBG_TRIG_DEFINES_SVH

// register indices, byte address is four times the index
`define IDX_IRQ_CAUSE 8'h15
`define IDX_IRQ_DATA 8'h16
`define IDX_STOP_MASK 8'h18
`define IDX_SCRATCH 8'h20
`define IDX_IBRK_ADDR 8'h30
`define IDX_IBRK_CTRL 8'h40
`define IDX_DW_ADDR_A 8'h50
`define IDX_DW_ADDR_B 8'h60
`define IDX_DW_CTRL 8'h70
`define IDX_RW_MASK 8'h80
`define IDX_RW_VALUE 8'h90
`define IDX_RW_CTRL 8'h9C

// cause register fields
`define CAUSE_CODE_MSB 2
`define CAUSE_THREAD_LSB 8
`define CAUSE_THREAD_MSB 15
`define CAUSE_INDEX_LSB 16
`define CAUSE_INDEX_MSB 17

// cause codes
`define CAUSE_HOST 3'h1
`define CAUSE_DEBUG_CALL_INSTRUCTION 3'h2
`define CAUSE_IBRK 3'h3
`define CAUSE_DWATCH 3'h4
`define CAUSE_RWATCH 3'h5

// trigger control fields
`define CTRL_ENABLE_BIT 0
`define CTRL_SENSE_BIT 1
`define CTRL_LOAD_BIT 2
`define CTRL_THREAD_LSB 16
`define CTRL_THREAD_MSB 23
`define IBRK_CTRL_MASK 32'h00FF0003
`define DW_CTRL_MASK 32'h00FF0007
`define RW_CTRL_MASK 32'h00FF0003

// reset values
`define CTRL_RESET 32'h00000000
`define CAUSE_RESET 32'h00000000
`define WORD_RESET 32'h00000000
`define STOP_RESET 8'h00

`endif

// ===== design/dbg_trig_pkg.sv
// types shared by the debug trigger unit files
package dbg_trig_pkg;

  // one instruction issue seen by the breakpoint comparators
  typedef struct packed {
    logic valid;
    logic [7:0] thread;
    logic [31:0] pc;
  } instr_probe_t;

  // one memory access seen by the data watchpoints
  typedef struct packed {
    logic valid;
    logic is_load;
    logic [7:0] thread;
    logic [31:0] addr;
  } data_probe_t;

  // one resource operation seen by the resource watchpoints
  typedef struct packed {
    logic valid;
    logic [7:0] thread;
    logic [31:0] res_id;
  } res_probe_t;

  // debug call instruction executed by a thread
  typedef struct packed {
    logic valid;
    logic [7:0] thread;
  } debug_call_instruction_probe_t;

endpackage : dbg_trig_pkg

// ===== design/scratch_ram.sv
// eight-word scratch store with one write port and two registered read ports
`timescale 1ns/100ps
`default_nettype none
`include "dbg_trig_defines.svh"
module scratch_ram
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // write port
  input wire logic wr_en,
  input wire logic [2:0] wr_index,
  input wire logic [31:0] wr_data,
  // read port a
  input wire logic rd_a_en,
  input wire logic [2:0] rd_a_index,
  output logic [31:0] rd_a_data,
  // read port b
  input wire logic rd_b_en,
  input wire logic [2:0] rd_b_index,
  output logic [31:0] rd_b_data
);

  logic [31:0] mem_reg [8]; // storage words

  // storage, cleared at reset
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 8; i++)
      begin
        mem_reg[i] <= `WORD_RESET;
      end
    end
    else if (wr_en)
    begin
      mem_reg[wr_index] <= wr_data;
    end
  end

  // registered read data
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_a_data <= `WORD_RESET;
      rd_b_data <= `WORD_RESET;
    end
    else
    begin
      if (rd_a_en)
      begin
        rd_a_data <= mem_reg[rd_a_index];
      end
      if (rd_b_en)
      begin
        rd_b_data <= mem_reg[rd_b_index];
      end
    end
  end

endmodule : scratch_ram
`default_nettype wire

// ===== design/debug_breakpoint_watchpoint_unit.sv
// debug trigger unit: breakpoints, watchpoints, cause capture, stop mask, scratch
// How it works
// [RL1] cause code 3 bits, reset zero, five causes
// [RL2] trigger index, lowest fires first
// [RL3] index zero for host and debug call
// [RL4] thread number recorded, zero for host
// [RL5] data watch hit loads access address
// [RL6] resource watch hit loads resource identifier
// [RL7] stop mask holds threads outside debug mode
// [RL8] eight scratch words, also on config port
// [RL9] four pc breakpoints raise debug interrupt
// [RL10] per-thread enable field on every trigger
// [RL11] breakpoint sense bit: equal or differ
// [RL12] bit zero enables each trigger
// [RL13] watchpoint first and second address banks
// [RL14] watchpoint combine bit: and or or
// [RL15] watchpoint load bit allows load hits
// [RL16] resource watch mask and value registers
// [RL17] resource sense bit selects condition a/b
// [RL18] data conditions: match first, match second
// [RL19] resource conditions: masked equal, masked differ
`timescale 1ns/100ps
`default_nettype none
`include "dbg_trig_defines.svh"
module debug_breakpoint_watchpoint_unit
  import dbg_trig_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pipeline probes
  input wire instr_probe_t instr_probe,
  input wire data_probe_t data_probe,
  input wire res_probe_t res_probe,
  input wire debug_call_instruction_probe_t debug_call_instruction_probe,
  input wire logic host_req,
  input wire logic in_debug,
  // to the pipeline
  output logic debug_irq,
  output logic [7:0] thread_hold,
  // tile configuration view of the scratch words
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [2:0] cfg_index,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ready
);

  // register file state
  logic [31:0] ibrk_addr_reg [4]; // breakpoint addresses
  logic [31:0] ibrk_addr_next [4];
  logic [31:0] ibrk_ctrl_reg [4]; // breakpoint controls
  logic [31:0] ibrk_ctrl_next [4];
  logic [31:0] dw_a_reg [4]; // watch first address
  logic [31:0] dw_a_next [4];
  logic [31:0] dw_b_reg [4]; // watch second address
  logic [31:0] dw_b_next [4];
  logic [31:0] dw_ctrl_reg [4]; // watch controls
  logic [31:0] dw_ctrl_next [4];
  logic [31:0] rw_mask_reg [4]; // resource masks
  logic [31:0] rw_mask_next [4];
  logic [31:0] rw_value_reg [4]; // resource values
  logic [31:0] rw_value_next [4];
  logic [31:0] rw_ctrl_reg [4]; // resource controls
  logic [31:0] rw_ctrl_next [4];
  logic [2:0] cause_reg; // cause code
  logic [2:0] cause_next;
  logic [7:0] cause_thread_reg; // causing thread
  logic [7:0] cause_thread_next;
  logic [1:0] cause_index_reg; // trigger index
  logic [1:0] cause_index_next;
  logic [31:0] irq_data_reg; // trigger data
  logic [31:0] irq_data_next;
  logic [7:0] stop_reg; // stop mask
  logic [7:0] stop_next;
  logic irq_reg; // debug interrupt pulse
  logic irq_next;
  logic [7:0] hold_reg; // threads held
  logic [7:0] hold_next;
  logic [31:0] rdata_reg; // apb read data
  logic [31:0] rdata_next;
  logic err_reg; // apb error answer
  logic err_next;

  // bus decode
  logic setup; // setup phase
  logic wr_now; // write takes effect
  logic [7:0] idx; // register index
  logic [1:0] bank_sel; // entry within a bank
  logic scratch_hit; // index in scratch range
  logic mapped; // index maps a register
  logic apb_scratch_wr; // apb writes scratch
  logic [31:0] scratch_apb_data; // scratch read for apb

  // trigger hits
  logic [3:0] ib_hit;
  logic [3:0] dw_hit;
  logic [3:0] rw_hit;

  assign setup = psel & ~penable;
  assign wr_now = psel & penable & pwrite;
  assign idx = paddr[9:2];
  assign bank_sel = idx[1:0];
  assign scratch_hit = (idx[7:3] == 5'(`IDX_SCRATCH >> 3));
  assign apb_scratch_wr = wr_now & scratch_hit;

  // zero wait state slave
  assign pready = 1'b1;
  assign pslverr = err_reg;
  assign debug_irq = irq_reg;
  assign thread_hold = hold_reg;
  // config port waits while apb writes the scratch
  assign cfg_ready = ~apb_scratch_wr; // [RL8]

  // index of the lowest set bit of a hit vector
  function automatic logic [1:0] lowest(input logic [3:0] v);
    logic [1:0] r;
    r = 2'd0;
    for (int i = 3; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = 2'(i);
      end
    end
    return r;
  endfunction : lowest

  // thread enable check, only threads 0 to 7 exist
  function automatic logic thread_ok(input logic [31:0] ctrl, input logic [7:0] thr);
    logic [7:0] en;
    en = ctrl[`CTRL_THREAD_MSB:`CTRL_THREAD_LSB];
    return (thr[7:3] == 5'd0) & en[thr[2:0]];
  endfunction : thread_ok

  // index within one of the four-entry banks
  function automatic logic in_bank(input logic [7:0] i, input logic [7:0] base);
    return i[7:2] == base[7:2];
  endfunction : in_bank

  // per-trigger comparators
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_trig
      logic ib_eq;
      logic dw_ca;
      logic dw_cb;
      logic dw_cond;
      logic rw_eq;
      assign ib_eq = (instr_probe.pc == ibrk_addr_reg[g]); // [RL9]
      // compare sense: equal or differ
      assign ib_hit[g] = instr_probe.valid
        & ibrk_ctrl_reg[g][`CTRL_ENABLE_BIT] // [RL12]
        & thread_ok(ibrk_ctrl_reg[g], instr_probe.thread) // [RL10]
        & (ib_eq ^ ibrk_ctrl_reg[g][`CTRL_SENSE_BIT]); // [RL11]
      // condition a and b are address matches
      assign dw_ca = (data_probe.addr == dw_a_reg[g]); // [RL18]
      assign dw_cb = (data_probe.addr == dw_b_reg[g]); // [RL18]
      assign dw_cond = dw_ctrl_reg[g][`CTRL_SENSE_BIT] ? (dw_ca | dw_cb)
        : (dw_ca & dw_cb); // [RL14]
      // stores always watched, loads only when allowed
      assign dw_hit[g] = data_probe.valid & dw_cond
        & dw_ctrl_reg[g][`CTRL_ENABLE_BIT] // [RL12]
        & thread_ok(dw_ctrl_reg[g], data_probe.thread) // [RL10]
        & (~data_probe.is_load | dw_ctrl_reg[g][`CTRL_LOAD_BIT]); // [RL15]
      // masked identifier against masked value
      assign rw_eq = ((res_probe.res_id & rw_mask_reg[g])
        == (rw_value_reg[g] & rw_mask_reg[g])); // [RL19]
      assign rw_hit[g] = res_probe.valid
        & rw_ctrl_reg[g][`CTRL_ENABLE_BIT] // [RL12]
        & thread_ok(rw_ctrl_reg[g], res_probe.thread) // [RL10]
        & (rw_eq ^ rw_ctrl_reg[g][`CTRL_SENSE_BIT]); // [RL17]
    end
  endgenerate

  // trigger register banks, written by software only
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      ibrk_addr_next[i] = ibrk_addr_reg[i];
      ibrk_ctrl_next[i] = ibrk_ctrl_reg[i];
      dw_a_next[i] = dw_a_reg[i];
      dw_b_next[i] = dw_b_reg[i];
      dw_ctrl_next[i] = dw_ctrl_reg[i];
      rw_mask_next[i] = rw_mask_reg[i];
      rw_value_next[i] = rw_value_reg[i];
      rw_ctrl_next[i] = rw_ctrl_reg[i];
    end
    if (wr_now)
    begin
      // reserved control bits are dropped on write
      if (in_bank(idx, `IDX_IBRK_ADDR))
        ibrk_addr_next[bank_sel] = pwdata; // [RL9]
      if (in_bank(idx, `IDX_IBRK_CTRL))
        ibrk_ctrl_next[bank_sel] = pwdata & `IBRK_CTRL_MASK; // [RL12]
      if (in_bank(idx, `IDX_DW_ADDR_A))
        dw_a_next[bank_sel] = pwdata; // [RL13]
      if (in_bank(idx, `IDX_DW_ADDR_B))
        dw_b_next[bank_sel] = pwdata; // [RL13]
      if (in_bank(idx, `IDX_DW_CTRL))
        dw_ctrl_next[bank_sel] = pwdata & `DW_CTRL_MASK; // [RL15]
      if (in_bank(idx, `IDX_RW_MASK))
        rw_mask_next[bank_sel] = pwdata; // [RL16]
      if (in_bank(idx, `IDX_RW_VALUE))
        rw_value_next[bank_sel] = pwdata; // [RL16]
      if (in_bank(idx, `IDX_RW_CTRL))
        rw_ctrl_next[bank_sel] = pwdata & `RW_CTRL_MASK; // [RL17]
    end
  end

  // trigger register banks
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        ibrk_addr_reg[i] <= `WORD_RESET;
        ibrk_ctrl_reg[i] <= `CTRL_RESET; // [RL10]
        dw_a_reg[i] <= `WORD_RESET;
        dw_b_reg[i] <= `WORD_RESET;
        dw_ctrl_reg[i] <= `CTRL_RESET;
        rw_mask_reg[i] <= `WORD_RESET;
        rw_value_reg[i] <= `WORD_RESET;
        rw_ctrl_reg[i] <= `CTRL_RESET;
      end
    end
    else
    begin
      ibrk_addr_reg <= ibrk_addr_next;
      ibrk_ctrl_reg <= ibrk_ctrl_next;
      dw_a_reg <= dw_a_next;
      dw_b_reg <= dw_b_next;
      dw_ctrl_reg <= dw_ctrl_next;
      rw_mask_reg <= rw_mask_next;
      rw_value_reg <= rw_value_next;
      rw_ctrl_reg <= rw_ctrl_next;
    end
  end

  // cause capture: software write first, a hardware event overrides it
  always_comb
  begin
    cause_next = cause_reg;
    cause_thread_next = cause_thread_reg;
    cause_index_next = cause_index_reg;
    irq_data_next = irq_data_reg;
    stop_next = stop_reg;
    irq_next = 1'b0;
    // software writes
    if (wr_now && idx == `IDX_IRQ_CAUSE)
    begin
      cause_next = pwdata[`CAUSE_CODE_MSB:0];
      cause_thread_next = pwdata[`CAUSE_THREAD_MSB:`CAUSE_THREAD_LSB];
      cause_index_next = pwdata[`CAUSE_INDEX_MSB:`CAUSE_INDEX_LSB];
    end
    if (wr_now && idx == `IDX_IRQ_DATA)
      irq_data_next = pwdata;
    if (wr_now && idx == `IDX_STOP_MASK)
      stop_next = pwdata[7:0]; // [RL7]
    // new events only while the tile runs normally
    if (!in_debug)
    begin
      if (host_req)
      begin
        // host request: thread and index read zero
        irq_next = 1'b1;
        cause_next = `CAUSE_HOST; // [RL1]
        cause_thread_next = 8'h00; // [RL4]
        cause_index_next = 2'd0; // [RL3]
      end
      else if (debug_call_instruction_probe.valid)
      begin
        // debug call instruction
        irq_next = 1'b1;
        cause_next = `CAUSE_DEBUG_CALL_INSTRUCTION; // [RL1]
        cause_thread_next = debug_call_instruction_probe.thread; // [RL4]
        cause_index_next = 2'd0; // [RL3]
      end
      else if (|ib_hit)
      begin
        // instruction breakpoint
        irq_next = 1'b1; // [RL9]
        cause_next = `CAUSE_IBRK; // [RL1]
        cause_thread_next = instr_probe.thread; // [RL4]
        cause_index_next = lowest(ib_hit); // [RL2]
      end
      else if (|dw_hit)
      begin
        // data watchpoint, data is the access address
        irq_next = 1'b1;
        cause_next = `CAUSE_DWATCH; // [RL1]
        cause_thread_next = data_probe.thread; // [RL4]
        cause_index_next = lowest(dw_hit); // [RL2]
        irq_data_next = data_probe.addr; // [RL5]
      end
      else if (|rw_hit)
      begin
        // resource watchpoint, data is the resource id
        irq_next = 1'b1;
        cause_next = `CAUSE_RWATCH; // [RL1]
        cause_thread_next = res_probe.thread; // [RL4]
        cause_index_next = lowest(rw_hit); // [RL2]
        irq_data_next = res_probe.res_id; // [RL6]
      end
    end
    // masked threads stay stopped outside debug mode
    hold_next = in_debug ? 8'h00 : stop_next; // [RL7]
  end

  // cause, data, stop mask and interrupt pulse
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cause_reg <= 3'(`CAUSE_RESET); // [RL1]
      cause_thread_reg <= 8'h00;
      cause_index_reg <= 2'd0;
      irq_data_reg <= `WORD_RESET;
      stop_reg <= `STOP_RESET;
      irq_reg <= 1'b0;
      hold_reg <= `STOP_RESET;
    end
    else
    begin
      cause_reg <= cause_next;
      cause_thread_reg <= cause_thread_next;
      cause_index_reg <= cause_index_next;
      irq_data_reg <= irq_data_next;
      stop_reg <= stop_next;
      irq_reg <= irq_next;
      hold_reg <= hold_next;
    end
  end

  // read mux, sampled in the setup phase
  always_comb
  begin
    rdata_next = rdata_reg;
    err_next = err_reg;
    mapped = 1'b1;
    if (setup)
    begin
      rdata_next = 32'h00000000;
      if (idx == `IDX_IRQ_CAUSE)
      begin
        rdata_next[`CAUSE_INDEX_MSB:`CAUSE_INDEX_LSB] = cause_index_reg;
        rdata_next[`CAUSE_THREAD_MSB:`CAUSE_THREAD_LSB] = cause_thread_reg;
        rdata_next[`CAUSE_CODE_MSB:0] = cause_reg;
      end
      else if (idx == `IDX_IRQ_DATA)
        rdata_next = irq_data_reg;
      else if (idx == `IDX_STOP_MASK)
        rdata_next[7:0] = stop_reg;
      else if (scratch_hit)
        rdata_next = 32'h00000000; // filled from the ram below
      else if (in_bank(idx, `IDX_IBRK_ADDR))
        rdata_next = ibrk_addr_reg[bank_sel];
      else if (in_bank(idx, `IDX_IBRK_CTRL))
        rdata_next = ibrk_ctrl_reg[bank_sel];
      else if (in_bank(idx, `IDX_DW_ADDR_A))
        rdata_next = dw_a_reg[bank_sel];
      else if (in_bank(idx, `IDX_DW_ADDR_B))
        rdata_next = dw_b_reg[bank_sel];
      else if (in_bank(idx, `IDX_DW_CTRL))
        rdata_next = dw_ctrl_reg[bank_sel];
      else if (in_bank(idx, `IDX_RW_MASK))
        rdata_next = rw_mask_reg[bank_sel];
      else if (in_bank(idx, `IDX_RW_VALUE))
        rdata_next = rw_value_reg[bank_sel];
      else if (in_bank(idx, `IDX_RW_CTRL))
        rdata_next = rw_ctrl_reg[bank_sel];
      else
        mapped = 1'b0;
      // unmapped or high address bits set: error answer
      err_next = ~mapped | (paddr[31:10] != 22'd0) | (paddr[1:0] != 2'd0);
    end
  end

  // read data and error flops
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_reg <= `WORD_RESET;
      err_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  // scratch words: apb writes win, config port waits
  scratch_ram u_scratch
  (
    .mclk(mclk),
    .nrst(nrst),
    .wr_en(apb_scratch_wr | (cfg_req & cfg_write & ~apb_scratch_wr)), // [RL8]
    .wr_index(apb_scratch_wr ? idx[2:0] : cfg_index),
    .wr_data(apb_scratch_wr ? pwdata : cfg_wdata),
    .rd_a_en(setup & scratch_hit),
    .rd_a_index(idx[2:0]),
    .rd_a_data(scratch_apb_data),
    .rd_b_en(cfg_req & ~cfg_write & cfg_ready),
    .rd_b_index(cfg_index),
    .rd_b_data(cfg_rdata)
  );

  // scratch data replaces the register mux only when selected
  logic scratch_rd_reg; // access phase reads scratch
  logic scratch_rd_next;
  always_comb
  begin
    scratch_rd_next = setup ? scratch_hit : scratch_rd_reg;
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      scratch_rd_reg <= 1'b0;
    else
      scratch_rd_reg <= scratch_rd_next;
  end
  assign prdata = scratch_rd_reg ? scratch_apb_data : rdata_reg;

endmodule : debug_breakpoint_watchpoint_unit
`default_nettype wire

// ===== sim/dbg_trig_checker.sv
// port assertions for the debug trigger unit
`timescale 1ns/100ps
`default_nettype none
module dbg_trig_checker
  import dbg_trig_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic pready,
  // probes
  input wire instr_probe_t instr_probe,
  input wire data_probe_t data_probe,
  input wire res_probe_t res_probe,
  input wire debug_call_instruction_probe_t debug_call_instruction_probe,
  input wire logic host_req,
  input wire logic in_debug,
  // results
  input wire logic debug_irq,
  input wire logic [7:0] thread_hold,
  input wire logic cfg_ready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // only the pc probe is active
  logic only_pc;
  assign only_pc = instr_probe.valid && !host_req && !debug_call_instruction_probe.valid
    && !data_probe.valid && !res_probe.valid;
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_host; host_req && !in_debug |=> debug_irq; endproperty
  a_host: assert property (p_host) else $error("host request lost");
  property p_call; debug_call_instruction_probe.valid && !in_debug |=> debug_irq; endproperty
  a_call: assert property (p_call) else $error("debug call lost");
  property p_quiet; in_debug |=> !debug_irq; endproperty
  a_quiet: assert property (p_quiet) else $error("event taken in debug mode");
  property p_hold; in_debug [*2] |-> thread_hold == 8'h00; endproperty
  a_hold: assert property (p_hold) else $error("threads held in debug mode");
  property p_none;
    !host_req && !debug_call_instruction_probe.valid && !instr_probe.valid && !data_probe.valid
      && !res_probe.valid |=> !debug_irq;
  endproperty
  a_none: assert property (p_none) else $error("event without a cause");
  property p_thr; only_pc && instr_probe.thread[7:3] != 5'h00 |=> !debug_irq; endproperty
  a_thr: assert property (p_thr) else $error("break on unknown thread");
  property p_cfg;
    psel && penable && pwrite && paddr[31:5] == 27'h0000004 && paddr[1:0] == 2'h0
      |-> !cfg_ready;
  endproperty
  a_cfg: assert property (p_cfg) else $error("scratch port clash");
endmodule : dbg_trig_checker
bind debug_breakpoint_watchpoint_unit dbg_trig_checker dbg_trig_checker_i (.mclk, .nrst,
  .psel, .penable, .pwrite, .paddr, .pready, .instr_probe, .data_probe, .res_probe,
  .debug_call_instruction_probe, .host_req, .in_debug, .debug_irq, .thread_hold, .cfg_ready);
`default_nettype wire

// ===== sim/pipe_model.sv
// thread pipeline model that raises one probe event per call
`timescale 1ns/100ps
`default_nettype none
module pipe_model
  import dbg_trig_pkg::*;
(
  // clock
  input wire logic mclk,
  // probes toward the unit
  output var instr_probe_t instr_probe,
  output var data_probe_t data_probe,
  output var res_probe_t res_probe,
  output var debug_call_instruction_probe_t debug_call_instruction_probe,
  output var logic host_req
);
  initial
  begin
    instr_probe = '0;
    data_probe = '0;
    res_probe = '0;
    debug_call_instruction_probe = '0;
    host_req = 1'b0;
  end
  // kind 0 pc, 1 access, 2 resource, 3 call, 4 host; one cycle each
  task automatic fire(input int k, input logic [7:0] t, input logic [31:0] v,
    input logic ld);
  begin
    @(posedge mclk);
    case (k)
      0: instr_probe <= {1'b1, t, v};
      1: data_probe <= {1'b1, ld, t, v};
      2: res_probe <= {1'b1, t, v};
      3: debug_call_instruction_probe <= {1'b1, t};
      default: host_req <= 1'b1;
    endcase
    @(posedge mclk);
    // stale payload flips so it never passes for a fresh event
    instr_probe <= {1'b0, ~instr_probe[39:0]};
    data_probe <= {1'b0, ~data_probe[40:0]};
    res_probe <= {1'b0, ~res_probe[39:0]};
    debug_call_instruction_probe <= {1'b0, ~debug_call_instruction_probe[7:0]};
    host_req <= 1'b0;
  end
  endtask : fire
endmodule : pipe_model
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the debug trigger unit
`timescale 1ns/100ps
`default_nettype none
`include "dbg_trig_defines.svh"
module tb
  import dbg_trig_pkg::*;
;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic pready, pslverr, in_debug = 1'b0, host_req, debug_irq, cfg_ready;
  logic cfg_req = 1'b0, cfg_write = 1'b0;
  logic [2:0] cfg_index = 3'h0;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, q;
  logic [7:0] thread_hold;
  instr_probe_t instr_probe;
  data_probe_t data_probe;
  res_probe_t res_probe;
  debug_call_instruction_probe_t debug_call_instruction_probe;
  int err_total = 0, checks = 0, cyc = 0;
  logic e;
  // 40 MHz clock
  always #12.5 mclk = ~mclk;
  debug_breakpoint_watchpoint_unit debug_breakpoint_watchpoint_unit_i (.mclk, .nrst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .instr_probe,
    .data_probe, .res_probe, .debug_call_instruction_probe, .host_req, .in_debug, .debug_irq,
    .thread_hold, .cfg_req, .cfg_write, .cfg_index, .cfg_wdata, .cfg_rdata, .cfg_ready);
  pipe_model pipe_model_i (.mclk, .instr_probe, .data_probe, .res_probe, .debug_call_instruction_probe,
    .host_req);
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
  begin
    checks++;
    if (got !== ex)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  end
  endtask : chk
  // one apb transfer, held until pready at an edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
  begin
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask : apb
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
  begin
    apb(1'b1, {22'h0, i, 2'h0}, d);
  end
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [31:0] ex);
  begin
    apb(1'b0, {22'h0, i, 2'h0}, 32'h0);
    chk("register", ex, q);
    chk("pslverr", 32'h0, {31'h0, e});
  end
  endtask : rd
  // one probe event, then the pulse one edge later
  task automatic hit(input int k, input logic [7:0] t, input logic [31:0] v,
    input logic ld, input logic ex);
  begin
    pipe_model_i.fire(k, t, v, ld);
    #1;
    chk("debug_irq", {31'h0, ex}, {31'h0, debug_irq});
  end
  endtask : hit
  task automatic t_regs;
    logic [7:0] b [5];
  begin
    b = '{`IDX_IBRK_ADDR, `IDX_DW_ADDR_A, `IDX_DW_ADDR_B, `IDX_RW_MASK, `IDX_RW_VALUE};
    rd(`IDX_IRQ_CAUSE, 32'h0);
    rd(`IDX_IBRK_CTRL + 8'h3, 32'h0);
    rd(`IDX_RW_CTRL + 8'h3, 32'h0);
    for (int j = 0; j < 20; j++)
    begin
      wr(b[j / 4] + 8'(j % 4), 32'hA5C30000 + j);
      rd(b[j / 4] + 8'(j % 4), 32'hA5C30000 + j);
    end
    wr(`IDX_DW_CTRL + 8'h2, 32'hFFFFFFFF);
    rd(`IDX_DW_CTRL + 8'h2, 32'h00FF0007);
    wr(`IDX_DW_CTRL + 8'h2, 32'h0);
    wr(`IDX_STOP_MASK, 32'hFFFFFF05);
    rd(`IDX_STOP_MASK, 32'h00000005);
    apb(1'b0, 32'h00000004, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
  end
  endtask : t_regs
  task automatic t_trig;
  begin
    hit(4, 8'h07, 32'h0, 1'b0, 1'b1);
    rd(`IDX_IRQ_CAUSE, 32'h00000001);
    hit(3, 8'h05, 32'h0, 1'b0, 1'b1);
    rd(`IDX_IRQ_CAUSE, 32'h00000502);
    wr(`IDX_IBRK_ADDR + 8'h1, 32'h200);
    wr(`IDX_IBRK_ADDR + 8'h2, 32'h200);
    for (int i = 0; i < 3; i++)
    begin
      wr(`IDX_IBRK_CTRL + 8'(i), 32'h00080001);
    end
    hit(0, 8'h03, 32'h200, 1'b0, 1'b1);
    rd(`IDX_IRQ_CAUSE, 32'h00010303);
    hit(0, 8'h04, 32'h200, 1'b0, 1'b0);
    hit(0, 8'h0B, 32'h200, 1'b0, 1'b0);
    wr(`IDX_IBRK_CTRL, 32'h00080003);
    hit(0, 8'h03, 32'h300, 1'b0, 1'b1);
    rd(`IDX_IRQ_CAUSE, 32'h00000303);
    wr(`IDX_IBRK_CTRL, 32'h00080002);
    hit(0, 8'h03, 32'h300, 1'b0, 1'b0);
    wr(`IDX_DW_ADDR_A, 32'h1000);
    wr(`IDX_DW_ADDR_B, 32'h2000);
    wr(`IDX_DW_CTRL, 32'h00010001);
    hit(1, 8'h00, 32'h1000, 1'b0, 1'b0);
    wr(`IDX_DW_CTRL, 32'h00010003);
    hit(1, 8'h00, 32'h1000, 1'b0, 1'b1);
    rd(`IDX_IRQ_CAUSE, 32'h00000004);
    rd(`IDX_IRQ_DATA, 32'h1000);
    hit(1, 8'h00, 32'h2000, 1'b1, 1'b0);
    wr(`IDX_DW_CTRL, 32'h00010007);
    hit(1, 8'h00, 32'h2000, 1'b1, 1'b1);
    rd(`IDX_IRQ_DATA, 32'h2000);
    wr(`IDX_RW_MASK + 8'h3, 32'h0000FF00);
    wr(`IDX_RW_VALUE + 8'h3, 32'h00001200);
    wr(`IDX_RW_CTRL + 8'h3, 32'h00020001);
    hit(2, 8'h01, 32'h00AB12CD, 1'b0, 1'b1);
    rd(`IDX_IRQ_CAUSE, 32'h00030105);
    rd(`IDX_IRQ_DATA, 32'h00AB12CD);
    wr(`IDX_RW_CTRL + 8'h3, 32'h00020003);
    hit(2, 8'h01, 32'h00AB12CD, 1'b0, 1'b0);
    hit(2, 8'h01, 32'h00003400, 1'b0, 1'b1);
  end
  endtask : t_trig
  task automatic t_stop;
  begin
    chk("thread_hold", 32'h05, {24'h0, thread_hold});
    @(posedge mclk);
    in_debug <= 1'b1;
    hit(4, 8'h00, 32'h0, 1'b0, 1'b0);
    chk("thread_hold", 32'h00, {24'h0, thread_hold});
    @(posedge mclk);
    in_debug <= 1'b0;
    wr(`IDX_SCRATCH + 8'h2, 32'h5A5A0022);
    cfg_req <= 1'b1;
    cfg_index <= 3'h2;
    @(posedge mclk);
    cfg_write <= 1'b1;
    cfg_index <= 3'h5;
    cfg_wdata <= 32'hC0DE0005;
    #1;
    chk("cfg_rdata", 32'h5A5A0022, cfg_rdata);
    @(posedge mclk);
    cfg_req <= 1'b0;
    rd(`IDX_SCRATCH + 8'h5, 32'hC0DE0005);
    chk("thread_hold", 32'h05, {24'h0, thread_hold});
  end
  endtask : t_stop
  task automatic end_of_test;
  begin
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  end
  endtask : end_of_test
  // hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_trig();
    t_stop();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
